// [logic/card_io_window_pkg.sv]
// Constants for the card I/O window decode block
package card_io_window_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_MAP_ENABLE = 8'h06;
  localparam logic [7:0] IDX_IO_WINDOW_CONTROL = 8'h07;
  localparam logic [7:0] IDX_WIN0_START_LOW = 8'h08;
  localparam logic [7:0] IDX_WIN0_START_HIGH = 8'h09;
  localparam logic [7:0] IDX_WIN0_END_LOW = 8'h0a;
  localparam logic [7:0] IDX_WIN0_END_HIGH = 8'h0b;
  localparam logic [7:0] IDX_WIN1_START_LOW = 8'h0c;
  localparam logic [7:0] IDX_WIN1_START_HIGH = 8'h0d;
  localparam logic [7:0] IDX_WIN1_END_LOW = 8'h0e;
  localparam logic [7:0] IDX_WIN1_END_HIGH = 8'h0f;
  // Spacing between windows in index units
  localparam logic [7:0] WIN_STRIDE = 8'h04;
  // Control register fields
  localparam int CTL_WIN0_SIZE = 0;
  localparam int CTL_WIN0_AUTO = 1;
  localparam int CTL_WIN0_TIMING = 3;
  localparam int CTL_WIN1_SIZE = 4;
  localparam int CTL_WIN1_AUTO = 5;
  localparam int CTL_WIN1_TIMING = 7;
  localparam int CTL_FIELD_STRIDE = 4;
  // Mapping enable fields
  localparam int MAP_IO_WIN0_EN = 6;
  localparam int MAP_IO_WIN1_EN = 7;
  localparam logic [7:0] MAP_WRITABLE = 8'hdf;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Host I/O request status readback
  localparam logic [7:0] IDX_DECODE_STATUS = 8'h20;
  localparam logic [7:0] IDX_LAST_ADDR_LOW = 8'h21;
  localparam logic [7:0] IDX_LAST_ADDR_HIGH = 8'h22;
endpackage : card_io_window_pkg

// [logic/io_window_match.sv]
// Address range compare for one I/O window
`timescale 1ns/10ps
module io_window_match #(
  parameter int AW = 16
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] start_addr,
  input wire logic [AW-1:0] end_addr,
  input wire logic enable,
  output logic hit
);
  assign hit = enable && (addr >= start_addr) && (addr <= end_addr);
endmodule : io_window_match

// [logic/card_io_window_decode.sv]
// APB register file and host I/O window decode for one socket
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// - With window 0 auto sizing off, control bit 0 picks 8-bit (0) or 16-bit (1) path.
// - With control bit 1 set, window 0 width follows the card wide I/O indication.
// - Control bit 3 picks timing set 0 or 1 for window 0 accesses.
// - With window 1 auto sizing off, control bit 4 picks 8-bit (0) or 16-bit (1) path.
// - With control bit 5 set, window 1 width follows the card wide I/O indication.
// - Control bit 7 picks timing set 0 or 1 for window 1 accesses.
// - An I/O address hits a window when start <= address <= end.
// - Each start address is 16 bits kept as separate low and high byte registers.
// - Start low bytes sit at indexes 08h and 0Ch, high bytes at 09h and 0Dh.
// - A window decodes only while its enable bit 6 or 7 of index 06h is set.
// - End low bytes sit at 0Ah and 0Eh, high bytes at 0Bh and 0Fh, all reset to zero.
module card_io_window_decode #(
  parameter int AW = 16,
  parameter int NWIN = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_req,
  input wire logic [AW-1:0] io_addr,
  input wire logic card_wide_io_indication_n,
  output logic card_io_hit,
  output logic card_io_window,
  output logic card_io_wide,
  output logic card_io_timing_set
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01
  } apb_state_t;

  apb_state_t state_q;
  apb_state_t state_d;
  logic [7:0] map_enable_q;
  logic [7:0] control_q;
  logic [7:0] start_lo_q [NWIN];
  logic [7:0] start_hi_q [NWIN];
  logic [7:0] end_lo_q [NWIN];
  logic [7:0] end_hi_q [NWIN];
  logic [AW-1:0] last_addr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic hit_q;
  logic window_q;
  logic wide_q;
  logic timing_q;

  wire logic [7:0] reg_index;
  wire logic access;
  wire logic word_aligned;
  wire logic [NWIN-1:0] win_hit;
  wire logic [NWIN-1:0] win_wide;
  wire logic [NWIN-1:0] win_timing;
  wire logic [NWIN-1:0] win_enable;
  wire logic any_hit;
  wire logic sel_win;
  wire logic card_wide;
  logic [7:0] read_byte;
  logic index_known;
  wire logic [7:0] status_byte;
  wire logic wr_map;
  wire logic wr_ctl;
  wire logic [7:0] map_enable_d;
  // Next values of the registered answer and decode outputs
  wire logic setup_seen;
  wire logic pready_d;
  wire logic pslverr_d;
  wire logic [31:0] prdata_d;
  wire logic hit_d;
  wire logic window_d;
  wire logic wide_d;
  wire logic timing_d;
  wire logic [AW-1:0] last_addr_d;

  localparam logic [7:0] IDX_BASE = card_io_window_pkg::IDX_WIN0_START_LOW;
  localparam logic [7:0] WIN_STRIDE = card_io_window_pkg::WIN_STRIDE;

  // Index of a register from its byte address
  function automatic logic [7:0] index_of(input logic [11:0] a);
    index_of = a[9:2];
  endfunction : index_of

  // True when an index falls in the register group of window w
  function automatic logic is_window_reg(input logic [7:0] idx, input int w);
    logic [7:0] base;
    base = IDX_BASE + WIN_STRIDE * 8'(w);
    is_window_reg = (idx >= base) && (idx < base + WIN_STRIDE);
  endfunction : is_window_reg

  // Byte slot inside a window group: start low, start high, end low, end high
  function automatic logic [1:0] window_slot(input logic [7:0] idx, input int w);
    logic [7:0] rel;
    rel = idx - IDX_BASE - WIN_STRIDE * 8'(w);
    window_slot = rel[1:0];
  endfunction : window_slot

  assign reg_index = index_of(paddr);
  assign word_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign access = psel && penable && (state_q == ST_ACCESS);
  assign card_wide = !card_wide_io_indication_n;

  // Window enables from the mapping register
  assign win_enable[0] = map_enable_q[card_io_window_pkg::MAP_IO_WIN0_EN];
  assign win_enable[1] = map_enable_q[card_io_window_pkg::MAP_IO_WIN1_EN];

  genvar g;
  generate
    for (g = 0; g < NWIN; g++) begin : g_win
      localparam int SZ = card_io_window_pkg::CTL_WIN0_SIZE
        + g * card_io_window_pkg::CTL_FIELD_STRIDE;
      localparam int AU = card_io_window_pkg::CTL_WIN0_AUTO
        + g * card_io_window_pkg::CTL_FIELD_STRIDE;
      localparam int TM = card_io_window_pkg::CTL_WIN0_TIMING
        + g * card_io_window_pkg::CTL_FIELD_STRIDE;
      wire logic [AW-1:0] win_start;
      wire logic [AW-1:0] win_end;
      // Start and end built from byte pairs
      assign win_start = {start_hi_q[g], start_lo_q[g]};
      assign win_end = {end_hi_q[g], end_lo_q[g]};
      io_window_match #(
        .AW(AW)
      ) u_match (
        .addr(io_addr),
        .start_addr(win_start),
        .end_addr(win_end),
        .enable(win_enable[g]),
        .hit(win_hit[g])
      );
      assign win_wide[g] = control_q[AU] ? card_wide : control_q[SZ];
      assign win_timing[g] = control_q[TM];
    end
  endgenerate

  assign any_hit = |win_hit;
  assign sel_win = !win_hit[0];

  // Bus sequencer: a setup cycle is always followed by exactly one access cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Last decode result as seen by software
  assign status_byte = {4'h0, timing_q, wide_q, window_q, hit_q};

  always_comb begin
    read_byte = 8'h00;
    index_known = 1'b1;
    case (reg_index)
      card_io_window_pkg::IDX_MAP_ENABLE: read_byte = map_enable_q;
      card_io_window_pkg::IDX_IO_WINDOW_CONTROL: read_byte = control_q;
      card_io_window_pkg::IDX_WIN0_START_LOW: read_byte = start_lo_q[0];
      card_io_window_pkg::IDX_WIN0_START_HIGH: read_byte = start_hi_q[0];
      card_io_window_pkg::IDX_WIN0_END_LOW: read_byte = end_lo_q[0];
      card_io_window_pkg::IDX_WIN0_END_HIGH: read_byte = end_hi_q[0];
      card_io_window_pkg::IDX_WIN1_START_LOW: read_byte = start_lo_q[1];
      card_io_window_pkg::IDX_WIN1_START_HIGH: read_byte = start_hi_q[1];
      card_io_window_pkg::IDX_WIN1_END_LOW: read_byte = end_lo_q[1];
      card_io_window_pkg::IDX_WIN1_END_HIGH: read_byte = end_hi_q[1];
      card_io_window_pkg::IDX_DECODE_STATUS: read_byte = status_byte;
      card_io_window_pkg::IDX_LAST_ADDR_LOW: read_byte = last_addr_q[7:0];
      card_io_window_pkg::IDX_LAST_ADDR_HIGH: read_byte = last_addr_q[15:8];
      default: index_known = 1'b0;
    endcase
    // Refused accesses read as zero
    if (!word_aligned) begin
      read_byte = 8'h00;
      index_known = 1'b0;
    end
  end

  // Writes land at the edge that closes the access phase
  wire logic wr_ok = access && pwrite && index_known;
  wire logic [7:0] wbyte = pwdata[7:0];

  // Write strobes per socket register
  assign wr_map = wr_ok && (reg_index == card_io_window_pkg::IDX_MAP_ENABLE);
  assign wr_ctl = wr_ok && (reg_index == card_io_window_pkg::IDX_IO_WINDOW_CONTROL);
  // Bit 5 of the mapping register stays zero
  assign map_enable_d = wbyte & card_io_window_pkg::MAP_WRITABLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      map_enable_q <= card_io_window_pkg::REG_RESET;
      control_q <= card_io_window_pkg::REG_RESET;
    end else begin
      state_q <= state_d;
      if (wr_map) begin
        map_enable_q <= map_enable_d;
      end
      if (wr_ctl) begin
        control_q <= wbyte;
      end
    end
  end

  generate
    for (g = 0; g < NWIN; g++) begin : g_regs
      wire logic win_wr;
      wire logic [1:0] slot;
      // Byte registers of one window group
      assign win_wr = wr_ok && is_window_reg(reg_index, g);
      assign slot = window_slot(reg_index, g);
      always_ff @(posedge clk) begin
        if (reset) begin
          start_lo_q[g] <= card_io_window_pkg::REG_RESET;
          start_hi_q[g] <= card_io_window_pkg::REG_RESET;
          end_lo_q[g] <= card_io_window_pkg::REG_RESET;
          end_hi_q[g] <= card_io_window_pkg::REG_RESET;
        end else if (win_wr) begin
          case (slot)
            2'h0: start_lo_q[g] <= wbyte;
            2'h1: start_hi_q[g] <= wbyte;
            2'h2: end_lo_q[g] <= wbyte;
            default: end_hi_q[g] <= wbyte;
          endcase
        end
      end
    end
  endgenerate

  // Answer is formed at the setup edge so it stands for the whole access cycle
  assign setup_seen = (state_d == ST_ACCESS);
  assign pready_d = setup_seen;
  assign pslverr_d = setup_seen && !index_known;
  assign prdata_d = {24'h000000, read_byte};

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      if (setup_seen) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // Hit lasts one cycle; window, width and timing hold until the next request
  assign hit_d = io_req && any_hit;
  assign window_d = io_req ? sel_win : window_q;
  assign wide_d = io_req ? (any_hit && win_wide[sel_win]) : wide_q;
  assign timing_d = io_req ? (any_hit && win_timing[sel_win]) : timing_q;
  assign last_addr_d = io_req ? io_addr : last_addr_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      hit_q <= 1'b0;
      window_q <= 1'b0;
      wide_q <= 1'b0;
      timing_q <= 1'b0;
      last_addr_q <= '0;
    end else begin
      hit_q <= hit_d;
      window_q <= window_d;
      wide_q <= wide_d;
      timing_q <= timing_d;
      last_addr_q <= last_addr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign card_io_hit = hit_q;
  assign card_io_window = window_q;
  assign card_io_wide = wide_q;
  assign card_io_timing_set = timing_q;
endmodule : card_io_window_decode

// [verification/card_io_window_decode_asserts.sv]
// Port checker for the card I/O window decode block
`timescale 1ns/10ps
module card_io_window_decode_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic io_req,
  input wire logic card_io_hit,
  input wire logic card_io_window,
  input wire logic card_io_wide,
  input wire logic card_io_timing_set
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ready; s_setup |=> s_access; endproperty
  property p_idle; !psel |=> !pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_nohit; !io_req |=> !card_io_hit; endproperty
  property p_win; !io_req |=> $stable(card_io_window); endproperty
  property p_path; !io_req |=> $stable({card_io_wide, card_io_timing_set}); endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_once: assert property (p_once) else $error("answer held too long");
  a_err: assert property (p_err) else $error("bad error answer");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_nohit: assert property (p_nohit) else $error("hit without request");
  a_win: assert property (p_win) else $error("window moved while idle");
  a_path: assert property (p_path) else $error("width or timing moved");
endmodule : card_io_window_decode_asserts
bind card_io_window_decode card_io_window_decode_asserts i_chk (.clk, .reset, .psel, .penable,
  .prdata, .pready, .pslverr, .io_req, .card_io_hit, .card_io_window, .card_io_wide,
  .card_io_timing_set);

// [verification/card_io_model.sv]
// Card side model returning the wide I/O indication
`timescale 1ns/10ps
module card_io_model (
  input wire logic io_req,
  input wire logic wide_card,
  output logic card_wide_io_indication_n
);
  // Line is pulled up, so it reads high while the card is not addressed
  assign card_wide_io_indication_n = !(io_req && wide_card);
endmodule : card_io_model

// [verification/card_io_window_decode_tb_top.sv]
// Self-checking bench for the card I/O window decode block
`timescale 1ns/10ps
module card_io_window_decode_tb_top;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, io_req, wide_card, wide_n, e;
  logic hit, win, wide, tset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] io_addr;
  int bad_count, check_count, cycles;
  card_io_window_decode i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .io_req, .io_addr, .card_wide_io_indication_n(wide_n),
    .card_io_hit(hit), .card_io_window(win), .card_io_wide(wide), .card_io_timing_set(tset));
  card_io_model i_card (.io_req, .wide_card, .card_wide_io_indication_n(wide_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // One APB transfer, then one idle cycle before the next setup
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    check({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    check({e, rd[30:0]}, {24'h0, x});
  endtask : rdchk
  // Expected bits are timing, wide, window, hit
  task automatic io(input logic [15:0] a, input logic w, input logic [3:0] x);
    io_req <= 1'b1;
    io_addr <= a;
    wide_card <= w;
    @(posedge clk);
    io_req <= 1'b0;
    wide_card <= 1'b0;
    @(posedge clk);
    if (x[0]) check({28'h0, tset, wide, win, hit}, {28'h0, x});
    else check({31'h0, hit}, 32'h0);
  endtask : io
  task automatic step(input logic [7:0] c, input logic [15:0] a, input logic w,
    input logic [3:0] x);
    wr(8'h07, c);
    io(a, w, x);
  endtask : step
  task automatic t_regs;
    for (int i = 6; i < 16; i++) rdchk(8'(i), 8'h00);
    apb(1'b1, 8'h30, 8'h5a);
    check({e, rd[30:0]}, 32'h80000000);
    wr(8'h06, 8'hff);
    rdchk(8'h06, 8'hdf);
    wr(8'h07, 8'hff);
    rdchk(8'h07, 8'hff);
  endtask : t_regs
  task automatic t_decode;
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h10);
    wr(8'h0a, 8'hff);
    wr(8'h0b, 8'h10);
    wr(8'h0c, 8'h80);
    wr(8'h0d, 8'h10);
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'h20);
    rdchk(8'h0c, 8'h80);
    rdchk(8'h0d, 8'h10);
    wr(8'h07, 8'h00);
    wr(8'h06, 8'hc0);
    io(16'h0fff, 1'b0, 4'h0);
    io(16'h1000, 1'b0, 4'h1);
    io(16'h10ff, 1'b0, 4'h1);
    io(16'h1080, 1'b0, 4'h1);
    io(16'h1100, 1'b0, 4'h3);
    io(16'h20ff, 1'b0, 4'h3);
    io(16'h2100, 1'b0, 4'h0);
    wr(8'h06, 8'h80);
    io(16'h1080, 1'b0, 4'h3);
    wr(8'h06, 8'h00);
    io(16'h1100, 1'b0, 4'h0);
  endtask : t_decode
  task automatic t_width;
    wr(8'h06, 8'hc0);
    step(8'h00, 16'h1000, 1'b1, 4'h1);
    step(8'h01, 16'h1000, 1'b0, 4'h5);
    step(8'h08, 16'h1000, 1'b0, 4'h9);
    step(8'h02, 16'h1000, 1'b1, 4'h5);
    step(8'h03, 16'h1000, 1'b0, 4'h1);
    step(8'h00, 16'h1100, 1'b1, 4'h3);
    step(8'h10, 16'h1100, 1'b0, 4'h7);
    step(8'h80, 16'h1100, 1'b0, 4'hb);
    step(8'h20, 16'h1100, 1'b1, 4'h7);
    step(8'h30, 16'h1100, 1'b0, 4'h3);
    rdchk(8'h20, 8'h02);
    rdchk(8'h21, 8'h00);
    rdchk(8'h22, 8'h11);
  endtask : t_width
  // Reset in mid-run clears registers and decode outputs
  task automatic t_reset;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({28'h0, tset, wide, win, hit}, 32'h0);
    rdchk(8'h07, 8'h00);
    rdchk(8'h06, 8'h00);
    rdchk(8'h0d, 8'h00);
    io(16'h1100, 1'b0, 4'h0);
  endtask : t_reset
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {reset, psel, penable, pwrite, io_req, wide_card} = 6'h20;
    {paddr, pwdata, io_addr} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_decode();
    t_width();
    t_reset();
    summarize();
  end
endmodule : card_io_window_decode_tb_top
